/* hw/arsc_pkg.sv */
// Purpose: shared constants and carrier types for the converter result/status block
// Assumes: byte-wide special function register port, one system clock
// Notes: offsets are byte addresses in the special function register space
package arsc_pkg;
    // register offsets
    localparam logic [7:0] ADDR_DECIM_LOW = 8'h9a;
    localparam logic [7:0] ADDR_DECIM_HIGH = 8'h9b;
    localparam logic [7:0] ADDR_DAC = 8'hbb;
    localparam logic [7:0] ADDR_STATUS = 8'hc1;
    localparam logic [7:0] ADDR_RESULT_L = 8'hc3;
    localparam logic [7:0] ADDR_RESULT_M = 8'hc4;
    localparam logic [7:0] ADDR_RESULT_H = 8'hc5;
    localparam logic [7:0] ADDR_CONTROL = 8'he8;
    localparam logic [7:0] ADDR_MOD_CLK_DIV = 8'hf7;
    // reset values
    localparam logic [2:0] RST_DECIM_HIGH = 3'h7;
    localparam logic [7:0] RST_DECIM_LOW = 8'h00;
    localparam logic [7:0] RST_MOD_CLK_DIV = 8'h00;
    localparam logic [7:0] RST_DAC = 8'h00;
    // widths
    localparam int DECIM_W = 11;
    localparam int DECIM_HIGH_W = 3;
    localparam int RESULT_W = 24;
    localparam int FILT_W = 25;
    // converter state: one bit, gray by nature
    typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_CONVERT = 1'b1} arsc_state_t;
    // status register layout, bit 0 first from the right
    typedef struct packed {
        logic [2:0] spare;
        logic summary_error_flag;
        logic fast_filter_clip_flag;
        logic third_order_clip_flag;
        logic result_overrun_flag;
        logic conversion_complete_flag;
    } arsc_status_t;
    // control register layout
    typedef struct packed {
        logic [4:0] spare;
        logic burnout_current_enable;
        logic output_polarity_select;
        logic convert_enable;
    } arsc_control_t;
    // offset dac setting, sign and magnitude
    typedef struct packed {
        logic sign;
        logic [6:0] magnitude;
    } arsc_dac_t;
endpackage : arsc_pkg

/* hw/arsc_clk_div.sv */
// Purpose: modulator clock enable divided down from the system clock
// Assumes: divisor may change at any time; new value takes effect in the current count period
// Notes: tick period is divisor plus one system clock cycles
`timescale 1ns/1ps
`default_nettype none
module arsc_clk_div
    import arsc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [7:0] divisor,
    output logic tick
);
    logic [7:0] count;

    // free-running divider, compare with >= so a shrinking divisor cannot run away
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count <= 8'h00;
            tick <= 1'b0;
        end
        else if (count >= divisor)
        begin
            count <= 8'h00;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 8'h01;
            tick <= 1'b0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    property p_tick_spacing;
        tick && divisor != 8'h00 |=> !tick;
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("modulator tick too frequent");
endmodule : arsc_clk_div
`default_nettype wire

/* hw/arsc_decimator.sv */
// Purpose: counts modulator ticks into conversion periods
// Assumes: ratio is held stable while run is high
// Notes: a ratio of zero behaves as one
`timescale 1ns/1ps
`default_nettype none
module arsc_decimator
    import arsc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic run,
    input wire logic mod_tick,
    input wire logic [DECIM_W-1:0] ratio,
    output logic conv_end
);
    logic [DECIM_W-1:0] count;
    logic [DECIM_W-1:0] count_inc;

    assign count_inc = count + 11'h001;

    // one output word per ratio modulator samples
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count <= 11'h000;
            conv_end <= 1'b0;
        end
        else if (!run)
        begin
            count <= 11'h000;
            conv_end <= 1'b0;
        end
        else if (mod_tick && count_inc >= ratio)
        begin
            count <= 11'h000;
            conv_end <= 1'b1;
        end
        else
        begin
            if (mod_tick)
            begin
                count <= count_inc;
            end
            conv_end <= 1'b0;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    property p_end_needs_tick;
        conv_end |-> $past(mod_tick) && $past(run);
    endproperty
    a_end_needs_tick: assert property (p_end_needs_tick) else $error("conversion end without tick");
endmodule : arsc_decimator
`default_nettype wire

/* hw/arsc_top.sv */
// Purpose: result coding, status flags, offset dac, burnout and rate control of the converter
// Assumes: filter and modulator logic run on ref_clk; clip and calibration inputs are pulses
// Notes: filter value is signed, one unipolar step per unit, full scale at 2**24
`timescale 1ns/1ps
`default_nettype none
module arsc_top
    import arsc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic signed [FILT_W-1:0] filt_value,
    input wire logic third_order_clip,
    input wire logic fast_clip,
    input wire logic cal_limit_error,
    output logic modulator_clock,
    output logic conv_running,
    output logic burnout_en,
    output logic dac_sign,
    output logic [6:0] dac_magnitude,
    output logic dac_update
);
    arsc_state_t state;
    arsc_state_t next_state;
    arsc_control_t control;
    arsc_status_t status;
    arsc_status_t next_status;
    arsc_dac_t dac_setting;
    logic [7:0] mod_div;
    logic [DECIM_HIGH_W-1:0] decim_high;
    logic [7:0] decim_low;
    logic [RESULT_W-1:0] result;
    logic [7:0] next_rdata;
    logic mod_tick;
    logic conv_end;
    logic wr_control;
    logic wr_status;
    logic wr_dac;
    logic decim_unlocked;

    // write strobes per register
    assign wr_control = sfr_wr && sfr_addr == ADDR_CONTROL;
    assign wr_status = sfr_wr && sfr_addr == ADDR_STATUS;
    assign wr_dac = sfr_wr && sfr_addr == ADDR_DAC;
    assign decim_unlocked = state == ST_IDLE;

    // signed-binary to output coding
    function automatic logic [RESULT_W-1:0] code_result(
        input logic signed [FILT_W-1:0] v,
        input logic bipolar
    );
        logic signed [FILT_W-1:0] half;
        half = v >>> 1;
        if (bipolar)
        begin
            code_result = half[RESULT_W-1:0];
        end
        else if (v[FILT_W-1])
        begin
            code_result = 24'h000000;
        end
        else
        begin
            code_result = v[RESULT_W-1:0];
        end
    endfunction : code_result

    arsc_clk_div u_clk_div (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .divisor(mod_div),
        .tick(mod_tick)
    );

    arsc_decimator u_decimator (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .run(state == ST_CONVERT),
        .mod_tick(mod_tick),
        .ratio({decim_high, decim_low}),
        .conv_end(conv_end)
    );

    // converter runs while software holds the enable bit
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:
            begin
                if (control.convert_enable)
                begin
                    next_state = ST_CONVERT;
                end
            end
            ST_CONVERT:
            begin
                if (!control.convert_enable)
                begin
                    next_state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= ST_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // control and divisor registers
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            control <= '0;
            mod_div <= RST_MOD_CLK_DIV;
        end
        else
        begin
            if (wr_control)
            begin
                control <= {5'h00, sfr_wdata[2:0]};
            end
            if (sfr_wr && sfr_addr == ADDR_MOD_CLK_DIV)
            begin
                mod_div <= sfr_wdata;
            end
        end
    end

    // ratio writes while converting are dropped, counter must not see a moving target
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            decim_high <= RST_DECIM_HIGH;
            decim_low <= RST_DECIM_LOW;
        end
        else if (decim_unlocked)
        begin
            if (sfr_wr && sfr_addr == ADDR_DECIM_HIGH)
            begin
                decim_high <= sfr_wdata[DECIM_HIGH_W-1:0];
            end
            if (sfr_wr && sfr_addr == ADDR_DECIM_LOW)
            begin
                decim_low <= sfr_wdata;
            end
        end
    end

    // status flags: software writes 0 to clear, a set in the same cycle wins
    always_comb
    begin
        next_status = status;
        if (wr_status)
        begin
            next_status = status & {3'h0, sfr_wdata[4:0]};
        end
        next_status.spare = 3'h0;
        if (conv_end)
        begin
            next_status.conversion_complete_flag = 1'b1;
        end
        if (conv_end && status.conversion_complete_flag)
        begin
            next_status.result_overrun_flag = 1'b1;
        end
        if (third_order_clip)
        begin
            next_status.third_order_clip_flag = 1'b1;
        end
        if (fast_clip)
        begin
            next_status.fast_filter_clip_flag = 1'b1;
        end
        if (third_order_clip || fast_clip || cal_limit_error ||
            (conv_end && status.conversion_complete_flag))
        begin
            next_status.summary_error_flag = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status <= '0;
        end
        else
        begin
            status <= next_status;
        end
    end

    // results load every conversion, errors or not; an unread word is lost
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            result <= 24'h000000;
        end
        else if (conv_end)
        begin
            result <= code_result(filt_value, control.output_polarity_select);
        end
    end

    // offset dac: each write retriggers the update even with an equal value
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dac_setting <= RST_DAC;
            dac_update <= 1'b0;
        end
        else
        begin
            dac_update <= wr_dac;
            if (wr_dac)
            begin
                dac_setting <= sfr_wdata;
            end
        end
    end

    // analog-facing outputs, all registered
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            burnout_en <= 1'b0;
            dac_sign <= 1'b0;
            dac_magnitude <= 7'h00;
            modulator_clock <= 1'b0;
            conv_running <= 1'b0;
        end
        else
        begin
            burnout_en <= control.burnout_current_enable;
            dac_sign <= dac_setting.sign;
            dac_magnitude <= dac_setting.magnitude;
            modulator_clock <= mod_tick;
            conv_running <= state == ST_CONVERT;
        end
    end

    // read mux, unmapped addresses return zero
    always_comb
    begin
        next_rdata = 8'h00;
        unique case (sfr_addr)
            ADDR_DECIM_LOW: next_rdata = decim_low;
            ADDR_DECIM_HIGH: next_rdata = {5'h00, decim_high};
            ADDR_DAC: next_rdata = dac_setting;
            ADDR_STATUS: next_rdata = status;
            ADDR_RESULT_L: next_rdata = result[7:0];
            ADDR_RESULT_M: next_rdata = result[15:8];
            ADDR_RESULT_H: next_rdata = result[23:16];
            ADDR_CONTROL: next_rdata = control;
            ADDR_MOD_CLK_DIV: next_rdata = mod_div;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sfr_rdata <= 8'h00;
        end
        else if (sfr_rd)
        begin
            sfr_rdata <= next_rdata;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    property p_unipolar;
        conv_end && !control.output_polarity_select |=>
            result == ($past(filt_value[24]) ? 24'h000000 : $past(filt_value[23:0]));
    endproperty
    a_unipolar: assert property (p_unipolar) else $error("unipolar coding wrong");

    property p_bipolar;
        conv_end && control.output_polarity_select |=> result == $past(filt_value[24:1]);
    endproperty
    a_bipolar: assert property (p_bipolar) else $error("bipolar coding wrong");

    property p_third_clip;
        third_order_clip |=> status.third_order_clip_flag && status.summary_error_flag;
    endproperty
    a_third_clip: assert property (p_third_clip) else $error("third-order clip lost");

    property p_fast_clip;
        fast_clip |=> status.fast_filter_clip_flag && status.summary_error_flag;
    endproperty
    a_fast_clip: assert property (p_fast_clip) else $error("fast clip lost");

    // the overwritten word must be the new conversion, equal values included
    property p_overrun;
        conv_end && status.conversion_complete_flag |=>
            status.result_overrun_flag && status.summary_error_flag &&
            result == ($past(control.output_polarity_select) ? $past(filt_value[24:1]) :
            ($past(filt_value[24]) ? 24'h000000 : $past(filt_value[23:0])));
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not flagged");

    property p_cal_error;
        cal_limit_error |=> status.summary_error_flag;
    endproperty
    a_cal_error: assert property (p_cal_error) else $error("calibration error lost");

    property p_complete;
        conv_end |=> status.conversion_complete_flag;
    endproperty
    a_complete: assert property (p_complete) else $error("complete flag not set");

    property p_dac_write;
        wr_dac |=> dac_update ##1 dac_sign == $past(sfr_wdata[7], 2) &&
            dac_magnitude == $past(sfr_wdata[6:0], 2);
    endproperty
    a_dac_write: assert property (p_dac_write) else $error("dac update wrong");

    property p_burnout;
        burnout_en == $past(control.burnout_current_enable);
    endproperty
    a_burnout: assert property (p_burnout) else $error("burnout on without enable");

    property p_decim_lock;
        state == ST_CONVERT |=> $stable(decim_high) && $stable(decim_low);
    endproperty
    a_decim_lock: assert property (p_decim_lock) else $error("ratio changed while converting");

    property p_decim_read;
        sfr_rd && sfr_addr == ADDR_DECIM_HIGH |=> sfr_rdata[7:3] == 5'h00;
    endproperty
    a_decim_read: assert property (p_decim_read) else $error("ratio high spare bits set");

    c_overrun: cover property (conv_end && status.conversion_complete_flag);
    c_bipolar: cover property (conv_end && control.output_polarity_select);
    c_dac: cover property (wr_dac);
    c_locked_write: cover property (sfr_wr && sfr_addr == ADDR_DECIM_HIGH && !decim_unlocked);
endmodule : arsc_top
`default_nettype wire

/* testbench/arsc_fe_model.sv */
// Purpose: stand-in for the modulator, filters and analog front end
// Assumes: bench sets the input level and asks for overflow pulses
// Notes: outside a conversion the filter word is inverted, so stale data shows
`timescale 1ns/1ps
`default_nettype none
module arsc_fe_model
    import arsc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic conv_running,
    input wire logic burnout_en,
    input wire logic signed [FILT_W-1:0] level,
    input wire logic [2:0] clip_req,
    output logic signed [FILT_W-1:0] filt_value,
    output logic third_order_clip,
    output logic fast_clip,
    output logic cal_limit_error
);
    // open input with burnout sources on reads full scale positive
    always_comb
    begin
        if (!conv_running)
            filt_value = ~level;
        else if (burnout_en)
            filt_value = 25'h0ffffff;
        else
            filt_value = level;
    end

    // overflow and calibration limit pulses, one cycle each
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            {cal_limit_error, fast_clip, third_order_clip} <= 3'h0;
        else
            {cal_limit_error, fast_clip, third_order_clip} <= clip_req;
    end
endmodule : arsc_fe_model
`default_nettype wire

/* testbench/adc_result_status_control_tb.sv */
// Purpose: self-checking bench for the converter result/status block
// Assumes: ratio 64, divisor 1, so one conversion takes about 128 cycles
// Notes: plain conversions run from a table, the awkward cases follow it
`timescale 1ns/1ps
`default_nettype none
module adc_result_status_control_tb
    import arsc_pkg::*;
;
    typedef struct packed {logic pol; logic [24:0] lvl; logic [23:0] exp;} arsc_row_t;
    localparam arsc_row_t ROWS [11] = '{
        {1'b0, 25'h0000000, 24'h000000}, {1'b0, 25'h0000001, 24'h000001},
        {1'b0, 25'h0800000, 24'h800000}, {1'b0, 25'h0ffffff, 24'hffffff},
        {1'b0, 25'h1fffffb, 24'h000000}, {1'b1, 25'h0fffffe, 24'h7fffff},
        {1'b1, 25'h0800000, 24'h400000}, {1'b1, 25'h0000002, 24'h000001},
        {1'b1, 25'h1fffffe, 24'hffffff}, {1'b1, 25'h1800000, 24'hc00000},
        {1'b1, 25'h1000000, 24'h800000}};
    // address and reset value pairs, the last one unmapped
    localparam logic [15:0] RV [6] = '{16'h9b07, 16'h9a00, 16'hf700, 16'hc100,
        16'he800, 16'h8000};
    logic ref_clk, arst_n, sfr_wr, sfr_rd, mod_clk, running, burnout_en;
    logic third_clip, fast_clip, cal_err, dac_sign, dac_update;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, s;
    logic [6:0] dac_magnitude;
    logic [2:0] clip_req;
    logic signed [FILT_W-1:0] lvl, filt_value;
    logic [23:0] res;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc_cnt = 0;
    int cyc;

    arsc_top u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .filt_value(filt_value), .third_order_clip(third_clip), .fast_clip(fast_clip),
        .cal_limit_error(cal_err), .modulator_clock(mod_clk), .conv_running(running),
        .burnout_en(burnout_en), .dac_sign(dac_sign), .dac_magnitude(dac_magnitude),
        .dac_update(dac_update));

    arsc_fe_model u_fe (.ref_clk(ref_clk), .arst_n(arst_n), .conv_running(running),
        .burnout_en(burnout_en), .level(lvl), .clip_req(clip_req),
        .filt_value(filt_value), .third_order_clip(third_clip), .fast_clip(fast_clip),
        .cal_limit_error(cal_err));

    // 200 MHz system clock and a free cycle count for timing checks
    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc_cnt <= cyc_cnt + 1;

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done();
        if (error_cnt == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : test_done

    // one-cycle write strobe, released just after the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        sfr_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge ref_clk);
        #1;
        sfr_rd = 1'b0;
        d = sfr_rdata;
    endtask : rd

    // bounded poll of one status bit
    task automatic wait_st(input int b, output logic [7:0] st);
        st = 8'h00;
        for (int i = 0; i < 200 && st[b] !== 1'b1; i++)
            rd(ADDR_STATUS, st);
    endtask : wait_st

    task automatic conv(input logic [7:0] ctl, output logic [23:0] r, output int c);
        logic [7:0] st, h, m, l;
        int t0;
        wr(ADDR_CONTROL, ctl);
        t0 = cyc_cnt;
        wait_st(0, st);
        c = cyc_cnt - t0;
        wr(ADDR_CONTROL, ctl & 8'hfe);
        chk({16'h0000, st}, 24'h000001);
        rd(ADDR_RESULT_H, h);
        rd(ADDR_RESULT_M, m);
        rd(ADDR_RESULT_L, l);
        r = {h, m, l};
        wr(ADDR_STATUS, 8'h00);
    endtask : conv

    // watchdog, far beyond the few thousand cycles the tests need
    initial
    begin
        #(40000 * 5);
        error_cnt++;
        test_done();
    end

    initial
    begin
        {sfr_addr, sfr_wdata, sfr_wr, sfr_rd, clip_req} = '0;
        lvl = '0;
        arst_n = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1;
        arst_n = 1'b1;
        foreach (RV[i])
        begin
            rd(RV[i][15:8], s);
            chk({16'h0000, s}, {16'h0000, RV[i][7:0]});
        end
        wr(ADDR_DECIM_HIGH, 8'hff);
        wr(8'h80, 8'h5a);
        rd(ADDR_DECIM_HIGH, s);
        chk({16'h0000, s}, 24'h000007);
        rd(8'h80, s);
        chk({16'h0000, s}, 24'h000000);
        // ratio 64, modulator tick every 2 cycles
        wr(ADDR_DECIM_HIGH, 8'h00);
        wr(ADDR_DECIM_LOW, 8'h40);
        wr(ADDR_MOD_CLK_DIV, 8'h01);
        rd(ADDR_MOD_CLK_DIV, s);
        chk({16'h0000, s}, 24'h000001);
        // divisor 1: the modulator clock pulses every other cycle
        s = {7'h00, mod_clk};
        @(posedge ref_clk);
        #1;
        chk({23'h0, mod_clk}, {23'h0, ~s[0]});
        for (int i = 0; i < 11; i++)
        begin
            lvl = ROWS[i].lvl;
            conv({6'h00, ROWS[i].pol, 1'b1}, res, cyc);
            chk(res, ROWS[i].exp);
            if (i == 0)
                chk({23'h0, cyc >= 126 && cyc <= 142}, 24'h000001);
        end
        // overrun: complete left set, ratio write refused mid-conversion
        lvl = 25'h0000010;
        wr(ADDR_CONTROL, 8'h01);
        wr(ADDR_DECIM_HIGH, 8'h05);
        chk({23'h0, running}, 24'h000001);
        wait_st(0, s);
        lvl = 25'h0000020;
        wait_st(1, s);
        wr(ADDR_CONTROL, 8'h00);
        rd(ADDR_STATUS, s);
        chk({16'h0000, s}, 24'h000013);
        chk({23'h0, running}, 24'h000000);
        rd(ADDR_RESULT_L, s);
        chk({16'h0000, s}, 24'h000020);
        rd(ADDR_DECIM_HIGH, s);
        chk({16'h0000, s}, 24'h000000);
        wr(ADDR_STATUS, 8'h00);
        // third-order clip, fast clip, calibration limit in turn
        for (int k = 0; k < 3; k++)
        begin
            @(posedge ref_clk);
            #1;
            clip_req = 3'h1 << k;
            @(posedge ref_clk);
            #1;
            clip_req = 3'h0;
            rd(ADDR_STATUS, s);
            chk({16'h0000, s}, {16'h0000, 8'h10 | (k < 2 ? 8'h04 << k : 8'h00)});
            wr(ADDR_STATUS, 8'h10);
            rd(ADDR_STATUS, s);
            chk({16'h0000, s}, 24'h000010);
            wr(ADDR_STATUS, 8'h00);
        end
        // offset dac: negative sign, magnitude 5
        wr(ADDR_DAC, 8'h85);
        chk({23'h0, dac_update}, 24'h000001);
        @(posedge ref_clk);
        #1;
        chk({16'h0000, dac_sign, dac_magnitude}, 24'h000085);
        chk({23'h0, dac_update}, 24'h000000);
        // burnout follows its bit, then a reset while it is on, converter idle
        wr(ADDR_CONTROL, 8'h04);
        @(posedge ref_clk);
        #1;
        chk({23'h0, burnout_en}, 24'h000001);
        arst_n = 1'b0;
        #1;
        chk({22'h0, burnout_en, dac_sign}, 24'h000000);
        repeat (2) @(posedge ref_clk);
        #1;
        arst_n = 1'b1;
        rd(ADDR_DECIM_HIGH, s);
        chk({16'h0000, s}, 24'h000007);
        test_done();
    end
endmodule : adc_result_status_control_tb
`default_nettype wire
